// [rtl/fault_flag_consts.svh]
// Constants for the LED fault flag status registers
`ifndef FAULT_FLAG_CONSTS_SVH
`define FAULT_FLAG_CONSTS_SVH

// ----------------------------------------------------------------
// Register selects on the read link
// ----------------------------------------------------------------
`define SEL_LINES_UPPER    2'h0
`define SEL_LINES_LOWER    2'h1
`define SEL_OPEN_CHANNELS  2'h2
`define SEL_SHORT_CHANNELS 2'h3

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define FLAG_WORD_W        48
`define LINE_COUNT         64
`define UPPER_LINE_BASE    48
`define UPPER_VALID_W      16
`define UPPER_RSVD_W       32
`define UPPER_RSVD_VAL     32'h0000_0000

// ----------------------------------------------------------------
// Reset values and shift timing
// ----------------------------------------------------------------
`define FLAG_WORD_RST      48'h0000_0000_0000
`define UPPER_FIELD_RST    16'h0000
`define SHIFT_LAST_BIT     6'h2F

`endif

// [rtl/fault_flag_pkg.sv]
// Types shared by the fault flag register bank and its read shifter
package fault_flag_pkg;
   typedef logic [47:0] flag_word_t;
   typedef logic [1:0]  reg_sel_t;
   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_WAIT,
      LINK_SHIFT
   } link_state_t;
endpackage

// [rtl/fault_flag_regs.sv]
// LED fault flag status register bank read out over the serial link
//
// Behaviour
// R1 - Lines 48..63 short warnings sit in bits 15..0 of the upper-line reg.
// R2 - Lines 0..47 short warnings sit in bits 47..0 of the lower-line reg.
// R3 - Each of 48 channels has an open-load flag, one for fault.
// R4 - All these fields are read-only; host writes never change them.
// R5 - Channel 0 open-load status is bit 0 and reads zero when normal.
// R6 - Each of 48 channels has a short flag, one for shorted.
// R7 - The controller reads every register shifted out on the data pin.
// R8 - Bits 47..16 of the upper-line register read as zero.
`include "fault_flag_consts.svh"

module fault_flag_regs
   import fault_flag_pkg::*;
#(
   parameter int FLAG_W = `FLAG_WORD_W
)
(
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   input  wire logic [`LINE_COUNT-1:0]   line_short_warning_bits,
   input  wire logic [FLAG_W-1:0]        channel_open_load_bits,
   input  wire logic [FLAG_W-1:0]        channel_short_bits,
   input  wire logic                     link_clk,
   input  wire logic                     read_start,
   input  wire reg_sel_t                 read_sel,
   output logic                          serial_data_out_pin,
   output logic                          serial_valid
);

   // ----------------------------------------------------------------
   // Status registers, loaded only from the detectors
   // ----------------------------------------------------------------
   logic [`UPPER_VALID_W-1:0] upper_r;
   logic [`UPPER_VALID_W-1:0] upper_nxt;
   flag_word_t                lower_r;
   flag_word_t                lower_nxt;
   flag_word_t                open_r;
   flag_word_t                open_nxt;
   flag_word_t                short_r;
   flag_word_t                short_nxt;

   // No write path exists, so nothing but detection moves these
   always_comb begin
      upper_nxt = line_short_warning_bits[`LINE_COUNT-1:`UPPER_LINE_BASE]; // R1
      lower_nxt = line_short_warning_bits[`UPPER_LINE_BASE-1:0]; // R2
      open_nxt  = channel_open_load_bits; // R3 R5
      short_nxt = channel_short_bits; // R6
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         upper_r <= `UPPER_FIELD_RST;
         lower_r <= `FLAG_WORD_RST;
         open_r  <= `FLAG_WORD_RST;
         short_r <= `FLAG_WORD_RST;
      end else begin
         upper_r <= upper_nxt; // R4
         lower_r <= lower_nxt; // R4
         open_r  <= open_nxt; // R4
         short_r <= short_nxt; // R4
      end
   end

   // ----------------------------------------------------------------
   // Read handshake, reference clock side
   // ----------------------------------------------------------------
   logic       req_toggle;
   reg_sel_t   sel_held;
   logic       req_s1_r;
   logic       req_s2_r;
   logic       req_s3_r;
   logic       capture;
   flag_word_t sel_word;
   flag_word_t hold_r;
   flag_word_t hold_nxt;
   logic       ack_r;
   logic       ack_nxt;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end else begin
         req_s1_r <= req_toggle;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end

   assign capture = req_s2_r ^ req_s3_r;

   // Selector is held by the link side until the ack returns
   always_comb begin
      case (sel_held)
         `SEL_LINES_UPPER:    sel_word = {`UPPER_RSVD_VAL, upper_r}; // R8
         `SEL_LINES_LOWER:    sel_word = lower_r;
         `SEL_OPEN_CHANNELS:  sel_word = open_r;
         `SEL_SHORT_CHANNELS: sel_word = short_r;
         default:             sel_word = `FLAG_WORD_RST;
      endcase
   end

   always_comb begin
      hold_nxt = hold_r;
      ack_nxt  = ack_r;
      if (capture) begin
         hold_nxt = sel_word; // R7
         ack_nxt  = ~ack_r;
      end
   end

   // Hold word only changes on a new request, so the shifter sees it steady
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hold_r <= `FLAG_WORD_RST;
         ack_r  <= 1'b0;
      end else begin
         hold_r <= hold_nxt;
         ack_r  <= ack_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Link side
   // ----------------------------------------------------------------
   flag_shifter u_shifter (
      .link_clk            (link_clk),
      .nrst                (nrst),
      .read_start          (read_start),
      .read_sel            (read_sel),
      .hold_word           (hold_r),
      .ack_toggle          (ack_r),
      .req_toggle          (req_toggle),
      .sel_held            (sel_held),
      .serial_data_out_pin (serial_data_out_pin),
      .serial_valid        (serial_valid)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   upper_map_a: assert property ( // R1
      @(posedge ref_clk) disable iff (!nrst)
      $past(nrst) |-> upper_r == $past(line_short_warning_bits[63:48]))
      else $error("upper line warnings not mapped to bits 15..0");

   lower_map_a: assert property ( // R2
      @(posedge ref_clk) disable iff (!nrst)
      $past(nrst) |-> lower_r == $past(line_short_warning_bits[47:0]))
      else $error("lower line warnings not mapped to bits 47..0");

   open_map_a: assert property ( // R3
      @(posedge ref_clk) disable iff (!nrst)
      $past(nrst) |-> open_r == $past(channel_open_load_bits))
      else $error("open-load flags do not follow the channels");

   chan0_normal_a: assert property ( // R5
      @(posedge ref_clk) disable iff (!nrst)
      !channel_open_load_bits[0] |=> !open_r[0])
      else $error("channel 0 open-load bit set while normal");

   short_map_a: assert property ( // R6
      @(posedge ref_clk) disable iff (!nrst)
      $past(nrst) |-> short_r == $past(channel_short_bits))
      else $error("short flags do not follow the channels");

   upper_rsvd_a: assert property ( // R8
      @(posedge ref_clk) disable iff (!nrst)
      capture && sel_held == `SEL_LINES_UPPER |=> hold_r[47:16] == 32'h0)
      else $error("reserved upper bits not zero");

   hold_load_a: assert property ( // R7
      @(posedge ref_clk) disable iff (!nrst)
      capture |=> hold_r == $past(sel_word) && ack_r != $past(ack_r))
      else $error("selected word not captured with ack toggle");

   hold_steady_a: assert property ( // R4
      @(posedge ref_clk) disable iff (!nrst)
      !capture ##1 !capture |-> $stable(hold_r) && $stable(ack_r))
      else $error("read word changed without a request");

   // ----------------------------------------------------------------
   // Read capture checks
   // ----------------------------------------------------------------

   upper_read_a: assert property ( // R1
      @(posedge ref_clk) disable iff (!nrst)
      capture && sel_held == `SEL_LINES_UPPER
      |=> hold_r[15:0] == $past(upper_r))
      else $error("upper line warnings not captured for readout");

   lower_read_a: assert property ( // R2
      @(posedge ref_clk) disable iff (!nrst)
      capture && sel_held == `SEL_LINES_LOWER
      |=> hold_r == $past(lower_r))
      else $error("lower line warnings not captured for readout");

   open_read_a: assert property ( // R3
      @(posedge ref_clk) disable iff (!nrst)
      capture && sel_held == `SEL_OPEN_CHANNELS
      |=> hold_r == $past(open_r))
      else $error("open-load flags not captured for readout");

   short_read_a: assert property ( // R6
      @(posedge ref_clk) disable iff (!nrst)
      capture && sel_held == `SEL_SHORT_CHANNELS
      |=> hold_r == $past(short_r))
      else $error("short flags not captured for readout");

   chan0_read_a: assert property ( // R5
      @(posedge ref_clk) disable iff (!nrst)
      capture && sel_held == `SEL_OPEN_CHANNELS && !open_r[0]
      |=> !hold_r[0])
      else $error("channel 0 read as open while normal");

   chan0_fault_a: assert property ( // R3
      @(posedge ref_clk) disable iff (!nrst)
      channel_open_load_bits[0] |=> open_r[0])
      else $error("channel 0 open load not flagged");

   capture_pulse_a: assert property ( // R7
      @(posedge ref_clk) disable iff (!nrst)
      capture |=> !capture)
      else $error("one request captured twice");

endmodule

// [rtl/flag_shifter.sv]
// Link-clock side: read request handshake and serial shift-out
`include "fault_flag_consts.svh"

module flag_shifter
   import fault_flag_pkg::*;
(
   input  wire logic       link_clk,
   input  wire logic       nrst,
   input  wire logic       read_start,
   input  wire reg_sel_t   read_sel,
   input  wire flag_word_t hold_word,
   input  wire logic       ack_toggle,
   output logic            req_toggle,
   output reg_sel_t        sel_held,
   output logic            serial_data_out_pin,
   output logic            serial_valid
);

   // ----------------------------------------------------------------
   // Crossings into the link domain
   // ----------------------------------------------------------------
   logic        rst_s1_r;
   logic        rst_s2_r;
   logic        ack_s1_r;
   logic        ack_s2_r;

   always_ff @(posedge link_clk) begin
      rst_s1_r <= nrst;
      rst_s2_r <= rst_s1_r;
      ack_s1_r <= ack_toggle;
      ack_s2_r <= ack_s1_r;
   end

   // ----------------------------------------------------------------
   // Request and shift state
   // ----------------------------------------------------------------
   link_state_t state_r;
   link_state_t state_nxt;
   logic        req_r;
   logic        req_nxt;
   reg_sel_t    sel_r;
   reg_sel_t    sel_nxt;
   flag_word_t  shift_r;
   flag_word_t  shift_nxt;
   logic [5:0]  cnt_r;
   logic [5:0]  cnt_nxt;

   always_comb begin
      state_nxt = state_r;
      req_nxt   = req_r;
      sel_nxt   = sel_r;
      shift_nxt = shift_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         LINK_IDLE: begin
            // Starts while busy are dropped; the word in flight is kept
            if (read_start) begin
               sel_nxt   = read_sel;
               req_nxt   = ~req_r;
               state_nxt = LINK_WAIT;
            end
         end
         LINK_WAIT: begin
            // Hold word is stable once the ack matches our request
            if (ack_s2_r == req_r) begin
               shift_nxt = hold_word; // R7
               cnt_nxt   = 6'h00;
               state_nxt = LINK_SHIFT;
            end
         end
         LINK_SHIFT: begin
            shift_nxt = {shift_r[46:0], 1'b0}; // R7
            cnt_nxt   = cnt_r + 6'h01;
            if (cnt_r == `SHIFT_LAST_BIT) begin
               state_nxt = LINK_IDLE;
            end
         end
         default: begin
            state_nxt = LINK_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clk) begin
      if (!rst_s2_r) begin
         state_r <= LINK_IDLE;
         req_r   <= 1'b0;
         sel_r   <= `SEL_LINES_UPPER;
         shift_r <= `FLAG_WORD_RST;
         cnt_r   <= 6'h00;
      end else begin
         state_r <= state_nxt;
         req_r   <= req_nxt;
         sel_r   <= sel_nxt;
         shift_r <= shift_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign req_toggle          = req_r;
   assign sel_held            = sel_r;
   assign serial_data_out_pin = shift_r[47]; // R7
   assign serial_valid        = (state_r == LINK_SHIFT);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   busy_drop_a: assert property ( // R7
      @(posedge link_clk) disable iff (!rst_s2_r)
      read_start && state_r != LINK_IDLE
      |=> $stable(req_r) && $stable(sel_r))
      else $error("read start taken while busy");

   shift_done_a: assert property ( // R7
      @(posedge link_clk) disable iff (!rst_s2_r)
      state_r == LINK_SHIFT && cnt_r == `SHIFT_LAST_BIT
      |=> state_r == LINK_IDLE && shift_r == `FLAG_WORD_RST)
      else $error("shift did not end after 48 bits");

endmodule

// [testbench/flag_reader.sv]
// Controller model that requests a status word and shifts it in
module flag_reader
   import fault_flag_pkg::*;
(
   input  wire logic link_clk,
   input  wire logic serial_data_out_pin,
   input  wire logic serial_valid,
   output logic      read_start,
   output reg_sel_t  read_sel
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      read_start = 1'b0;
      read_sel   = 2'h0;
   end

   // Sampled on the falling edge, half a cycle clear of the launch
   // A set poke raises a start in mid-shift, which must be dropped
   task automatic fetch(input  reg_sel_t   s,
                        output flag_word_t w,
                        input  bit         poke = 1'b0);
      int n;
      w = 'x;
      n = 0;
      @(posedge link_clk);
      read_start <= 1'b1;
      read_sel   <= s;
      @(posedge link_clk);
      read_start <= 1'b0;
      // Select is not qualified now, so show a wrong value
      read_sel   <= ~s;
      do begin
         @(negedge link_clk);
         n++;
      end while (serial_valid !== 1'b1 && n < 40);
      if (n >= 40)
         return;
      for (int i = 47; i >= 0; i--) begin
         w[i] = (serial_valid === 1'b1) ? serial_data_out_pin : 1'bx;
         @(posedge link_clk);
         read_start <= poke && (i == 24);
         @(negedge link_clk);
      end
      if (serial_valid !== 1'b0)
         w = 'x;
   endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the fault flag status register bank
module testbench;
   import fault_flag_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic        ref_clk  = 1'b0;
   logic        link_clk = 1'b0;
   logic        nrst     = 1'b0;
   logic [63:0] lines    = 64'h0;
   flag_word_t  open_ch  = 48'h0;
   flag_word_t  short_ch = 48'h0;
   logic        read_start;
   reg_sel_t    read_sel;
   logic        sdo;
   logic        svalid;
   int          miscompares  = 0;
   int          total_checks = 0;
   int          cycles       = 0;

   always #25 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #16 link_clk = ~link_clk;
   end

   fault_flag_regs i_dut (
      .ref_clk                 (ref_clk),
      .nrst                    (nrst),
      .line_short_warning_bits (lines),
      .channel_open_load_bits  (open_ch),
      .channel_short_bits      (short_ch),
      .link_clk                (link_clk),
      .read_start              (read_start),
      .read_sel                (read_sel),
      .serial_data_out_pin     (sdo),
      .serial_valid            (svalid)
   );

   flag_reader i_ctrl (
      .link_clk            (link_clk),
      .serial_data_out_pin (sdo),
      .serial_valid        (svalid),
      .read_start          (read_start),
      .read_sel            (read_sel)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp_word(input string what, input flag_word_t e, g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic set_flags(input logic [63:0] l, input flag_word_t o, s);
      @(posedge ref_clk);
      lines    <= l;
      open_ch  <= o;
      short_ch <= s;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic rd(input reg_sel_t s, input flag_word_t e, string what);
      flag_word_t w;
      i_ctrl.fetch(s, w);
      cmp_word(what, e, w);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset_zero;
      rd(2'h0, 48'h0, "upper after reset");
      rd(2'h1, 48'h0, "lower after reset");
      rd(2'h2, 48'h0, "open after reset");
      rd(2'h3, 48'h0, "short after reset");
   endtask

   // Pattern then its inverse, so every line and channel bit is seen at both levels
   task automatic test_patterns;
      logic [63:0] l;
      flag_word_t  o;
      flag_word_t  s;
      l = 64'h8421_F0E1_D2C3_B4A5;
      o = 48'h8000_1234_5670;
      s = 48'h0001_FEDC_BA99;
      for (int k = 0; k < 2; k++) begin
         set_flags(l, o, s);
         rd(2'h0, {32'h0000_0000, l[63:48]}, "upper lines");
         rd(2'h1, l[47:0], "lower lines");
         rd(2'h2, o, "open channels");
         rd(2'h3, s, "short channels");
         l = ~l;
         o = ~o;
         s = ~s;
      end
   endtask

   task automatic test_channel0;
      set_flags(64'h0, 48'hFFFF_FFFF_FFFE, 48'h0);
      rd(2'h2, 48'hFFFF_FFFF_FFFE, "open ch0 normal");
   endtask

   // Back-to-back reads follow the detectors and nothing else
   task automatic test_live_follow;
      set_flags(64'h0, 48'h0, 48'h0000_0000_0001);
      rd(2'h3, 48'h0000_0000_0001, "short first");
      rd(2'h3, 48'h0000_0000_0001, "short again");
      set_flags(64'h0, 48'h0, 48'h8000_0000_0000);
      rd(2'h3, 48'h8000_0000_0000, "short changed");
   endtask

   // Start raised mid-shift is dropped: same word, no second frame
   task automatic test_busy_start;
      flag_word_t w;
      flag_word_t seen;
      seen = '0;
      set_flags(64'h0000_5A5A_0000_0000, 48'h0, 48'h0);
      i_ctrl.fetch(2'h1, w, 1'b1);
      cmp_word("lower with busy start", 48'h5A5A_0000_0000, w);
      repeat (16) begin
         @(negedge link_clk);
         if (svalid !== 1'b0)
            seen++;
      end
      cmp_word("frames after busy start", 48'h0, seen);
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      test_reset_zero();
      test_patterns();
      test_channel0();
      test_live_follow();
      test_busy_start();
      tally_and_finish();
   end
endmodule
